// File: i2cm_data_path.sv
// Master data, address and receive-count path of a two-wire bus controller.
// Assumes a one-cycle register port on ref_clk and open-drain pads outside.
`timescale 1ns/1ps
`default_nettype none

module i2cm_data_path
	import i2cm_pkg::*;
#(
	parameter int QUARTER = I2CM_QUARTER_CYC
)
(
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	// Register port.
	input  wire logic [31:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [15:0] rdata,
	// Interrupt.
	output logic             irq,
	// Serial clock pad.
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	// Serial data pad.
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------

	// All registered state of the block.
	typedef struct packed {
		i2cm_state_t          state;   // Engine state.
		logic [7:0]           qcnt;    // Quarter-bit timer.
		logic [1:0]           phase;   // Quarter within the bit.
		logic [3:0]           bitn;    // Bit slot, 8 is the acknowledge.
		logic [7:0]           shreg;   // Shift register.
		logic [7:0]           txcur;   // Byte now being sent.
		logic                 nack;    // Last acknowledge was missing.
		logic [7:0]           cur_cnt; // Bytes received so far.
		logic [8:0]           rx_cnt;  // Extend flag and count.
		logic [7:0]           first_addr_field_alt;    // First address byte.
		logic [7:0]           second_addr_field;    // Second address byte.
		logic [I2CM_EV_W-1:0] ists;    // Sticky events.
		logic [I2CM_EV_W-1:0] mask;    // Event enables.
		logic                 rxreq_d; // Receive request, one cycle ago.
		logic                 txreq_d; // Transmit request, one cycle ago.
		logic [15:0]          rdata;   // Read answer.
		logic                 scl_oe;  // Pulling the clock low.
		logic                 sda_oe;  // Pulling data low.
		logic                 scl_s1;  // Clock pin, first stage.
		logic                 scl_s2;  // Clock pin, second stage.
		logic                 sda_s1;  // Data pin, first stage.
		logic                 sda_s2;  // Data pin, second stage.
	} i2cm_core_t;

	i2cm_core_t s;      // Current state.
	i2cm_core_t next_s; // Next state.

	// FIFO connections.
	logic       rx_push;  // Store a received byte.
	logic       rx_pop;   // Software took a byte.
	logic [7:0] rx_data_byte;
	logic       rx_full;
	logic       rx_empty;
	logic       tx_push;  // Software wrote a byte.
	logic       tx_pop;   // Engine took a byte.
	logic [7:0] tx_head;
	logic [1:0] tx_count;
	logic       tx_full;
	logic       tx_empty;

	// Derived flags.
	logic       rx_data_request;
	logic       tx_space_request;
	logic [1:0] tx_fifo_level;
	logic       ten_bit;  // First byte carries the ten-bit prefix.
	logic       last;     // Current receive byte is the final one.
	logic       busy;
	logic       tick;     // Quarter-bit boundary.

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------

	// Receive store; software reads drain it.
	i2cm_fifo #(.WIDTH(I2CM_BYTE_W), .DEPTH(I2CM_FIFO_DEPTH)) u_rx_fifo (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.push      (rx_push),
		.push_data (s.shreg),
		.pop       (rx_pop),
		.head      (rx_data_byte),
		.count     (),
		.full      (rx_full),
		.empty     (rx_empty)
	);

	// Transmit store; the engine drains it.
	i2cm_fifo #(.WIDTH(I2CM_BYTE_W), .DEPTH(I2CM_FIFO_DEPTH)) u_tx_fifo (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.push      (tx_push),
		.push_data (wdata[7:0]),
		.pop       (tx_pop),
		.head      (tx_head),
		.count     (tx_count),
		.full      (tx_full),
		.empty     (tx_empty)
	);

	// The level and receive request follow the stores directly; the transmit request also needs the write direction.
	assign rx_data_request  = !rx_empty;
	assign tx_space_request = !s.first_addr_field_alt[I2CM_DIR_BIT] && !tx_full;
	assign tx_fifo_level    = {!tx_empty, tx_full};
	assign ten_bit          = (s.first_addr_field_alt[7:3] == I2CM_TEN_PREFIX);
	// The count holds bytes minus one, so a match marks the final byte.
	assign last    = !s.rx_cnt[I2CM_EXTEND_BIT] && (s.cur_cnt == s.rx_cnt[7:0]);
	assign busy    = (s.state != S_IDLE);
	assign irq     = |(s.ists & s.mask);
	assign rdata   = s.rdata;
	assign scl_oe  = s.scl_oe;
	assign sda_oe  = s.sda_oe;
	// Open-drain pads only ever pull low.
	assign scl_o   = 1'b0;
	assign sda_o   = 1'b0;
	assign tx_push = wr_en && (addr == I2CM_TX_DATA_ADDR) && !tx_full;
	assign rx_pop  = rd_en && (addr == I2CM_RX_DATA_ADDR) && !rx_empty;
	// A slave holding the clock low stretches the high quarter.
	assign tick    = (s.qcnt == '0) && !(busy && s.phase == 2'd2 && !s.scl_s2);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------

	// Register port, engine and event capture in one pass.
	always_comb
	begin
		logic                 go;
		logic [I2CM_EV_W-1:0] ev;
		logic [I2CM_EV_W-1:0] clr;
		go      = 1'b0;
		ev      = '0;
		clr     = '0;
		next_s  = s;
		rx_push = 1'b0;
		tx_pop  = 1'b0;
		// Read data stands for one cycle only.
		next_s.rdata = '0;
		// Two-stage synchronisers for the pads.
		next_s.scl_s1 = scl_i;
		next_s.scl_s2 = s.scl_s1;
		next_s.sda_s1 = sda_i;
		next_s.sda_s2 = s.sda_s1;

		// Register writes.
		if (wr_en)
		begin
			case (addr)
				I2CM_RX_COUNT_ADDR:   next_s.rx_cnt = wdata[8:0];
				I2CM_ADDR0_ADDR:      next_s.first_addr_field_alt = wdata[7:0];
				I2CM_ADDR1_ADDR:      next_s.second_addr_field = wdata[7:0];
				I2CM_CTRL_ADDR:       go = wdata[I2CM_GO_BIT] && !busy;
				I2CM_IRQ_STATUS_ADDR: clr = wdata[I2CM_EV_W-1:0];
				I2CM_IRQ_MASK_ADDR:   next_s.mask = wdata[I2CM_EV_W-1:0];
				default:              next_s.mask = s.mask; // Unmapped: ignored.
			endcase
		end

		// Register reads; unmapped addresses answer zero.
		if (rd_en)
		begin
			case (addr)
				I2CM_RX_DATA_ADDR:    next_s.rdata = {8'h00, rx_data_byte};
				I2CM_TX_DATA_ADDR:    next_s.rdata = {8'h00, s.txcur};
				I2CM_RX_COUNT_ADDR:   next_s.rdata = {7'h00, s.rx_cnt};
				I2CM_CUR_COUNT_ADDR:  next_s.rdata = {8'h00, s.cur_cnt};
				I2CM_ADDR0_ADDR:      next_s.rdata = {8'h00, s.first_addr_field_alt};
				I2CM_ADDR1_ADDR:      next_s.rdata = {8'h00, s.second_addr_field};
				I2CM_STATUS_ADDR:
				begin
					next_s.rdata                 = {14'h0000, tx_fifo_level};
					next_s.rdata[I2CM_TXREQ_BIT] = tx_space_request;
					next_s.rdata[I2CM_RXREQ_BIT] = rx_data_request;
					next_s.rdata[I2CM_BUSY_BIT]  = busy;
				end
				I2CM_IRQ_STATUS_ADDR: next_s.rdata = {10'h000, s.ists};
				I2CM_IRQ_MASK_ADDR:   next_s.rdata = {10'h000, s.mask};
				default:              next_s.rdata = I2CM_REG_RESET;
			endcase
		end

		// Quarter-bit timer; held at reload while idle.
		if (!busy || tick)
			next_s.qcnt = 8'(QUARTER - 1);
		else if (s.qcnt != '0)
			next_s.qcnt = s.qcnt - 8'h01;

		// Bus engine.
		unique case (s.state)
			S_IDLE:
			begin
				next_s.scl_oe = 1'b0;
				next_s.sda_oe = 1'b0;
				next_s.phase  = 2'd0;
				if (go)
				begin
					next_s.state   = S_START;
					next_s.cur_cnt = '0;
				end
			end
			S_START:
			begin
				// Data falls while the clock is high, then the clock falls.
				if (tick)
				begin
					next_s.phase = s.phase + 2'd1;
					if (s.phase == 2'd1)
						next_s.sda_oe = 1'b1;
					if (s.phase == 2'd3)
					begin
						next_s.scl_oe = 1'b1;
						next_s.state  = S_ADDR0;
						next_s.shreg  = s.first_addr_field_alt;
						next_s.bitn   = '0;
					end
				end
			end
			S_STOP:
			begin
				// Data low, clock high, then data rises.
				if (tick)
				begin
					next_s.phase = s.phase + 2'd1;
					unique case (s.phase)
						2'd0: next_s.sda_oe = 1'b1;
						2'd1: next_s.scl_oe = 1'b0;
						2'd2: next_s.sda_oe = 1'b0;
						2'd3:
						begin
							next_s.state    = S_IDLE;
							ev[I2CM_EV_DONE] = 1'b1;
						end
					endcase
				end
			end
			S_ADDR0, S_ADDR1, S_DTX, S_DRX:
			begin
				if (tick)
				begin
					next_s.phase = s.phase + 2'd1;
					unique case (s.phase)
						// Clock low: set up the data line.
						2'd0:
						begin
							if (s.state == S_DRX)
								next_s.sda_oe = (s.bitn == 4'd8) ? !last : 1'b0;
							else
								next_s.sda_oe = (s.bitn == 4'd8) ? 1'b0 : !s.shreg[7];
						end
						// Release the clock.
						2'd1: next_s.scl_oe = 1'b0;
						// Clock high: sample.
						2'd2:
						begin
							if (s.bitn == 4'd8)
								next_s.nack = s.sda_s2;
							else if (s.state == S_DRX)
								next_s.shreg = {s.shreg[6:0], s.sda_s2};
						end
						// Clock falls: next bit or end of byte.
						2'd3:
						begin
							next_s.scl_oe = 1'b1;
							if (s.bitn != 4'd8)
							begin
								next_s.bitn = s.bitn + 4'd1;
								if (s.state != S_DRX)
									next_s.shreg = {s.shreg[6:0], 1'b0};
							end
							else
							begin
								next_s.bitn = '0;
								if (s.state == S_DRX)
								begin
									rx_push          = 1'b1;
									ev[I2CM_EV_RX_OVF] = rx_full;
									next_s.cur_cnt   = s.cur_cnt + 8'h01;
									if (last)
										next_s.state = S_STOP;
								end
								else if (s.nack)
								begin
									next_s.state     = S_STOP;
									ev[I2CM_EV_NACK] = 1'b1;
								end
								else if (s.state == S_ADDR0 && ten_bit)
								begin
									next_s.state = S_ADDR1;
									next_s.shreg = s.second_addr_field;
								end
								else if (s.state != S_DTX && s.first_addr_field_alt[I2CM_DIR_BIT])
									next_s.state = S_DRX;
								else if (tx_empty)
								begin
									// Nothing left to send ends the transfer.
									next_s.state       = S_STOP;
									ev[I2CM_EV_TX_UND] = 1'b1;
								end
								else
								begin
									next_s.state = S_DTX;
									tx_pop       = 1'b1;
									next_s.shreg = tx_head;
									next_s.txcur = tx_head;
								end
							end
						end
					endcase
				end
			end
		endcase

		// Request edges become sticky events; a new event beats a clear.
		ev[I2CM_EV_RX_REQ] = rx_data_request && !s.rxreq_d;
		ev[I2CM_EV_TX_REQ] = tx_space_request && !s.txreq_d;
		next_s.rxreq_d     = rx_data_request;
		next_s.txreq_d     = tx_space_request;
		next_s.ists        = (s.ists & ~clr) | ev;
	end

	// State register.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s       <= '0;
			s.state <= S_IDLE;
			s.qcnt  <= 8'(QUARTER - 1);
			s.scl_s1 <= 1'b1;
			s.scl_s2 <= 1'b1;
			s.sda_s1 <= 1'b1;
			s.sda_s2 <= 1'b1;
		end
		else
			s <= next_s;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	rx_flag_a: assert property (rd_en && addr == I2CM_STATUS_ADDR
		|=> rdata[I2CM_RXREQ_BIT] == !$past(rx_empty))
		else $error("Receive request does not follow the receive store.");
	tx_flag_a: assert property (rd_en && addr == I2CM_STATUS_ADDR
		|=> rdata[I2CM_TXREQ_BIT] == (!$past(s.first_addr_field_alt[0]) && $past(tx_count) != 2'd2))
		else $error("Transmit request disagrees with direction and fill.");
	irq_gate_a: assert property ($rose(rx_data_request) && s.mask[0] |=> irq [*1])
		else $error("Enabled receive request raised no interrupt.");
	tx_level_a: assert property (tx_count == 2'd1 |-> tx_fifo_level == 2'b10)
		else $error("Transmit level wrong for one byte.");
	rx_pop_a: assert property (rd_en && addr == I2CM_RX_DATA_ADDR && !rx_empty |=> rdata[7:0] == $past(rx_data_byte))
		else $error("Receive read returned the wrong byte.");
	tx_push_a: assert property (wr_en && addr == I2CM_TX_DATA_ADDR && tx_count == 2'd0 |=> tx_count == 2'd1)
		else $error("Transmit write was not stored.");
	readback_a: assert property (rd_en && addr == I2CM_TX_DATA_ADDR |=> rdata == {8'h00, $past(s.txcur)})
		else $error("Transmit readback is not the byte in flight.");
	extend_a: assert property (rx_push && s.rx_cnt[8] |=> s.state == S_DRX)
		else $error("Extended read stopped at the count.");
	cur_count_a: assert property (rx_push |=> s.cur_cnt == $past(s.cur_cnt) + 8'h01)
		else $error("Current receive count did not advance by one.");
	first_byte_a: assert property ($rose(s.state == S_ADDR0) |-> s.shreg == s.first_addr_field_alt)
		else $error("First address byte not loaded.");
	second_byte_a: assert property (s.state == S_ADDR0 && ten_bit && tick && s.phase == 2'd3
		&& s.bitn == 4'd8 && !s.nack |=> s.state == S_ADDR1 && s.shreg == s.second_addr_field)
		else $error("Second address byte did not follow the acknowledged first byte.");

	cover_write_c: cover property (s.state == S_DTX ##1 s.state == S_STOP);
	cover_read_c: cover property (rx_push ##[1:1000] s.state == S_IDLE);
	cover_ten_c: cover property (s.state == S_ADDR0 ##1 s.state == S_ADDR1);

endmodule

`default_nettype wire

// File: i2cm_pkg.sv
// Shared constants and types for the two-wire master data path.
// Assumes a 50 MHz reference clock and a 32-bit byte-addressed register port.
`default_nettype none

package i2cm_pkg;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [31:0] I2CM_RX_DATA_ADDR    = 32'h40003408;
	localparam logic [31:0] I2CM_TX_DATA_ADDR    = 32'h4000340c;
	localparam logic [31:0] I2CM_RX_COUNT_ADDR   = 32'h40003410;
	localparam logic [31:0] I2CM_CUR_COUNT_ADDR  = 32'h40003414;
	localparam logic [31:0] I2CM_ADDR0_ADDR      = 32'h40003418;
	localparam logic [31:0] I2CM_ADDR1_ADDR      = 32'h4000341c;
	localparam logic [31:0] I2CM_STATUS_ADDR     = 32'h40003440;
	localparam logic [31:0] I2CM_CTRL_ADDR       = 32'h40003444;
	localparam logic [31:0] I2CM_IRQ_STATUS_ADDR = 32'h40003448;
	localparam logic [31:0] I2CM_IRQ_MASK_ADDR   = 32'h4000344c;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int          I2CM_RXREQ_BIT  = 3;
	localparam int          I2CM_TXREQ_BIT  = 2;
	localparam int          I2CM_BUSY_BIT   = 6;
	localparam int          I2CM_EXTEND_BIT = 8;
	localparam int          I2CM_DIR_BIT    = 0;
	localparam int          I2CM_GO_BIT     = 0;
	localparam logic [4:0]  I2CM_TEN_PREFIX = 5'h1e;
	localparam logic [15:0] I2CM_REG_RESET  = 16'h0000;

	// Interrupt event positions, shared by status and mask.
	localparam int I2CM_EV_RX_REQ = 0;
	localparam int I2CM_EV_TX_REQ = 1;
	localparam int I2CM_EV_DONE   = 2;
	localparam int I2CM_EV_RX_OVF = 3;
	localparam int I2CM_EV_NACK   = 4;
	localparam int I2CM_EV_TX_UND = 5;
	localparam int I2CM_EV_W      = 6;

	// ------------------------------------------------------------
	// Sizes and timing
	// ------------------------------------------------------------
	localparam int I2CM_BYTE_W     = 8;
	localparam int I2CM_FIFO_DEPTH = 2;
	localparam int I2CM_CLK_NS     = 20;
	localparam int I2CM_QUARTER_NS = 1250;
	// A least time, so the count rounds up.
	localparam int I2CM_QUARTER_CYC = (I2CM_QUARTER_NS + I2CM_CLK_NS - 1) / I2CM_CLK_NS;

	// Engine states, one-hot.
	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_START = 7'h02,
		S_ADDR0 = 7'h04,
		S_ADDR1 = 7'h08,
		S_DTX   = 7'h10,
		S_DRX   = 7'h20,
		S_STOP  = 7'h40
	} i2cm_state_t;

endpackage

`default_nettype wire

// File: i2cm_fifo.sv
// Small first-in first-out store built from flip-flops.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module i2cm_fifo
	import i2cm_pkg::*;
#(
	parameter int WIDTH = I2CM_BYTE_W,
	parameter int DEPTH = I2CM_FIFO_DEPTH
)
(
	// Clock and reset.
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	// Write side.
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	// Read side.
	input  wire logic             pop,
	output logic      [WIDTH-1:0] head,
	// Fill state.
	output logic [$clog2(DEPTH):0] count,
	output logic                   full,
	output logic                   empty
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// All state of the store.
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [$clog2(DEPTH):0]      cnt;
	} i2cm_fifo_st_t;

	i2cm_fifo_st_t s;       // Current state.
	i2cm_fifo_st_t next_s;  // Next state.
	logic          do_push; // Accepted push.
	logic          do_pop;  // Accepted pop.

	// Pointer step with wrap, shared by both pointers.
	function automatic logic [AW-1:0] i2cm_step(input logic [AW-1:0] p);
		i2cm_step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign full    = (s.cnt == ($clog2(DEPTH) + 1)'(DEPTH));
	assign empty   = (s.cnt == '0);
	assign count   = s.cnt;
	assign head    = s.mem[s.rp];
	// A push into a full store is dropped; the caller flags it.
	assign do_push = push && !full;
	assign do_pop  = pop && !empty;

	// Next-state logic.
	always_comb
	begin
		next_s = s;
		if (do_push)
		begin
			next_s.mem[s.wp] = push_data;
			next_s.wp        = i2cm_step(s.wp);
		end
		if (do_pop)
			next_s.rp = i2cm_step(s.rp);
		next_s.cnt = s.cnt + {{$clog2(DEPTH){1'b0}}, do_push} - {{$clog2(DEPTH){1'b0}}, do_pop};
	end

	// State register.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			s <= '0;
		else
			s <= next_s;
	end

endmodule

`default_nettype wire

// File: i2cm_slave_model.sv
// Behavioural two-wire target that faces the master data path.
// Assumes open-drain wires with pull-ups resolved by the bench.
`timescale 1ns/1ps
`default_nettype none

module i2cm_slave_model
(
	// Resolved bus wires.
	input  wire logic scl,
	input  wire logic sda,
	// Data pull-down, high while the target drives the wire low.
	output logic      sda_oe
);
	// ----------------------------------------
	// Frame state
	// ----------------------------------------
	logic [7:0] rx_log [0:7]; // Written bytes, kept for the bench to inspect.
	int         rx_n;         // Number of bytes logged so far.
	logic [7:0] sr;           // Incoming shift register.
	logic [7:0] tx_byte;      // Next byte returned on a read.
	int         bitn;         // Bit slot within the byte, 8 is the acknowledge.
	logic       active;       // Inside a frame.
	logic       tx_mode;      // Target is returning data.
	logic       first;        // Next byte is the first address byte.

	initial
	begin
		sda_oe = 1'b0;
		active = 1'b0;
		rx_n = 0;
		tx_byte = 8'h80;
	end

	// A falling data line with the clock high opens a frame.
	always @(negedge sda)
	begin
		if (scl)
		begin
			active = 1'b1;
			bitn = -1;
			tx_mode = 1'b0;
			first = 1'b1;
			sda_oe = 1'b0;
		end
	end

	// A rising data line with the clock high closes it.
	always @(posedge sda)
	begin
		if (scl)
		begin
			active = 1'b0;
			sda_oe = 1'b0;
		end
	end

	// Sample on the rising clock, MSB first; a master NACK ends a read.
	always @(posedge scl)
	begin
		if (active && bitn < 8 && !tx_mode)
			sr = {sr[6:0], sda};
		if (active && bitn == 8 && tx_mode)
		begin
			tx_byte = tx_byte + 8'h01;
			if (sda)
				active = 1'b0;
		end
	end

	// Change the data line only while the clock is low, so no false start or stop appears.
	always @(negedge scl)
	begin
		if (active)
		begin
			if (bitn == 8)
			begin
				if (!tx_mode)
				begin
					rx_log[rx_n % 8] = sr;
					rx_n++;
					// Bit 0 of the first byte picks the direction, 1 is read.
					if (first && sr[0])
						tx_mode = 1'b1;
					first = 1'b0;
				end
				bitn = 0;
			end
			else
				bitn++;
			// Every written byte is acknowledged, the ten-bit pair included.
			sda_oe = tx_mode ? (bitn < 8 && !tx_byte[7 - bitn]) : (bitn == 8);
		end
	end
endmodule

`default_nettype wire

// File: i2cm_data_path_tb.sv
// Self-checking bench for the master data path and its register port.
// Assumes the behavioural target model and pull-ups on both wires.
`timescale 1ns/1ps
`default_nettype none

module i2cm_data_path_tb
	import i2cm_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        ref_clk;    // 50 MHz clock.
	logic        nrst;       // Active-low reset.
	logic [31:0] addr;       // Register address.
	logic [15:0] wdata;      // Write data.
	logic        wr_en;      // Write strobe.
	logic        rd_en;      // Read strobe.
	logic [15:0] rdata;      // Read data.
	logic        irq;        // Interrupt level.
	logic        scl_oe;     // Master clock pull-down.
	logic        sda_oe;     // Master data pull-down.
	logic        slv_oe;     // Target data pull-down.
	logic        scl;        // Resolved clock wire.
	logic        sda;        // Resolved data wire.
	int          num_errors; // Mismatches seen.
	int          n_checks;   // Comparisons made.
	logic [15:0] v;          // Scratch read value.
	logic [15:0] c;          // Scratch count value.
	int          b;          // Log index at frame start.
	logic        seen_ff;    // Count reached 255.
	logic        wrapped;    // Count wrapped to 0.

	// Pull-ups win unless some party pulls low.
	assign scl = !scl_oe;
	assign sda = !(sda_oe || slv_oe);

	always #10 ref_clk = ~ref_clk;

	// A quarter of 2 gives a nominal 160 ns bit; the synchronised clock stretches it.
	i2cm_data_path #(.QUARTER(2)) dut (
		.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .irq(irq), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(), .sda_oe(sda_oe)
	);

	i2cm_slave_model slv (.scl(scl), .sda(sda), .sda_oe(slv_oe));

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample mid-cycle.
	task automatic rd(input logic [31:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		@(negedge ref_clk);
		d = rdata;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rchk(input logic [31:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask

	// Waits for the engine to go idle under a bound.
	task automatic wait_idle();
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < 3000; i++)
		begin
			rd(I2CM_STATUS_ADDR, v);
			if (!v[I2CM_BUSY_BIT])
				return;
		end
		chk("idle", 16'h0000, 16'h0040);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// The longest test is an extended read of about 260 bytes.
	initial
	begin
		#1600000;
		num_errors++;
		conclude();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		addr = 32'h00000000;
		wdata = 16'h0000;
		wr_en = 1'b0;
		rd_en = 1'b0;
		num_errors = 0;
		n_checks = 0;
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 6; i++)
			rchk(I2CM_RX_DATA_ADDR + 32'h4 * i, 16'h0000);
		rchk(I2CM_STATUS_ADDR, 16'h0004);
		rchk(32'h40003400, 16'h0000);
		chk("irq", 16'h0000, {15'h0000, irq});
		$display("reset test done");
		wr(I2CM_RX_COUNT_ADDR, 16'h0103);
		rchk(I2CM_RX_COUNT_ADDR, 16'h0103);
		wr(I2CM_CUR_COUNT_ADDR, 16'h00ff);
		rchk(I2CM_CUR_COUNT_ADDR, 16'h0000);
		$display("register test done");
		// Two bytes fill the store, a third is dropped.
		wr(I2CM_ADDR0_ADDR, 16'h0054);
		rchk(I2CM_ADDR0_ADDR, 16'h0054);
		wr(I2CM_TX_DATA_ADDR, 16'h00a1);
		rchk(I2CM_STATUS_ADDR, 16'h0006);
		wr(I2CM_TX_DATA_ADDR, 16'h00b2);
		rchk(I2CM_STATUS_ADDR, 16'h0003);
		wr(I2CM_TX_DATA_ADDR, 16'h00c3);
		b = slv.rx_n;
		wr(I2CM_CTRL_ADDR, 16'h0001);
		wait_idle();
		chk("log n", 16'h0003, 16'(slv.rx_n - b));
		chk("log0", 16'h0054, {8'h00, slv.rx_log[b % 8]});
		chk("log1", 16'h00a1, {8'h00, slv.rx_log[(b + 1) % 8]});
		chk("log2", 16'h00b2, {8'h00, slv.rx_log[(b + 2) % 8]});
		rchk(I2CM_TX_DATA_ADDR, 16'h00b2);
		rchk(I2CM_STATUS_ADDR, 16'h0004);
		// Transmit request rises, stop done and transmit underflow are held.
		rchk(I2CM_IRQ_STATUS_ADDR, 16'h0026);
		$display("write test done");
		wr(I2CM_ADDR0_ADDR, 16'h00f4);
		wr(I2CM_ADDR1_ADDR, 16'h005c);
		rchk(I2CM_ADDR1_ADDR, 16'h005c);
		wr(I2CM_TX_DATA_ADDR, 16'h003c);
		b = slv.rx_n;
		wr(I2CM_CTRL_ADDR, 16'h0001);
		wait_idle();
		chk("ten0", 16'h00f4, {8'h00, slv.rx_log[b % 8]});
		chk("ten1", 16'h005c, {8'h00, slv.rx_log[(b + 1) % 8]});
		chk("ten2", 16'h003c, {8'h00, slv.rx_log[(b + 2) % 8]});
		$display("ten-bit test done");
		// Two-byte read with the receive request interrupt enabled.
		wr(I2CM_IRQ_MASK_ADDR, 16'h0001);
		wr(I2CM_IRQ_STATUS_ADDR, 16'h003f);
		wr(I2CM_RX_COUNT_ADDR, 16'h0001);
		wr(I2CM_ADDR0_ADDR, 16'h0055);
		wr(I2CM_CTRL_ADDR, 16'h0001);
		wait_idle();
		rchk(I2CM_STATUS_ADDR, 16'h0008);
		rchk(I2CM_CUR_COUNT_ADDR, 16'h0002);
		chk("irq", 16'h0001, {15'h0000, irq});
		wr(I2CM_IRQ_MASK_ADDR, 16'h0000);
		repeat (2) @(posedge ref_clk);
		chk("irq", 16'h0000, {15'h0000, irq});
		wr(I2CM_IRQ_MASK_ADDR, 16'h0001);
		repeat (2) @(posedge ref_clk);
		chk("irq", 16'h0001, {15'h0000, irq});
		wr(I2CM_IRQ_STATUS_ADDR, 16'h0001);
		repeat (2) @(posedge ref_clk);
		chk("irq", 16'h0000, {15'h0000, irq});
		rchk(I2CM_RX_DATA_ADDR, 16'h0080);
		rchk(I2CM_STATUS_ADDR, 16'h0008);
		rchk(I2CM_RX_DATA_ADDR, 16'h0081);
		rchk(I2CM_STATUS_ADDR, 16'h0000);
		// Turning to write raises the transmit request.
		wr(I2CM_IRQ_MASK_ADDR, 16'h0002);
		wr(I2CM_ADDR0_ADDR, 16'h0054);
		repeat (2) @(posedge ref_clk);
		chk("irq", 16'h0001, {15'h0000, irq});
		wr(I2CM_IRQ_STATUS_ADDR, 16'h0002);
		repeat (2) @(posedge ref_clk);
		chk("irq", 16'h0000, {15'h0000, irq});
		$display("read test done");
		// Extended read drained as it runs until the count wraps.
		wr(I2CM_RX_COUNT_ADDR, 16'h0100);
		wr(I2CM_ADDR0_ADDR, 16'h0055);
		wr(I2CM_CTRL_ADDR, 16'h0001);
		seen_ff = 1'b0;
		wrapped = 1'b0;
		for (int i = 0; i < 12000 && !wrapped; i++)
		begin
			rd(I2CM_STATUS_ADDR, v);
			if (v[I2CM_RXREQ_BIT])
				rd(I2CM_RX_DATA_ADDR, v);
			rd(I2CM_CUR_COUNT_ADDR, c);
			if (c == 16'h00ff)
				seen_ff = 1'b1;
			if (seen_ff && c == 16'h0000)
				wrapped = 1'b1;
		end
		chk("wrap", 16'h0001, {15'h0000, wrapped});
		wr(I2CM_RX_COUNT_ADDR, 16'h0001);
		for (int i = 0; i < 3000; i++)
		begin
			rd(I2CM_STATUS_ADDR, v);
			if (v[I2CM_RXREQ_BIT])
				rd(I2CM_RX_DATA_ADDR, c);
			if (!v[I2CM_BUSY_BIT])
				break;
		end
		chk("busy", 16'h0000, v & 16'h0040);
		$display("extended read test done");
		conclude();
	end
endmodule

`default_nettype wire
